// ### src/sar_adc_pkg.sv
package sar_adc_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_INJECT = 8'h0C;
    localparam logic [7:0] ADDR_DIGDIS = 8'h10;
    localparam logic [7:0] ADDR_PORTIN = 8'h14;
    localparam logic [7:0] ADDR_TIMING = 8'h18;
    // control field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_MODE_HI = 2;
    localparam int CTRL_WAIT_READ = 3;
    localparam int CTRL_EIGHT_BIT = 4;
    localparam int CTRL_IMPROVED = 5;
    localparam int CTRL_CHAN_LO = 8;
    localparam int CTRL_CHAN_HI = 11;
    localparam int CTRL_STC_LO = 12;
    localparam int CTRL_STC_HI = 13;
    localparam int CTRL_CTC_LO = 14;
    localparam int CTRL_CTC_HI = 15;
    localparam int INJ_CHAN_LO = 0;
    localparam int INJ_CHAN_HI = 3;
    localparam int TIM_SAMPLE_LO = 0;
    localparam int TIM_SAMPLE_HI = 7;
    localparam int TIM_DIV_LO = 8;
    localparam int TIM_DIV_HI = 15;
    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] TIMING_RESET = 16'h0310;
    localparam logic [13:0] DIGDIS_RESET = 14'h0000;
    // timing counts in basic clock periods, except TAIL_SYS in system clocks
    localparam int CAL_BC = 12;
    localparam int STEP_BC = 4;
    localparam int TAIL_SYS = 6;
    localparam int STARTUP_CAL_BC = 64;

    typedef enum logic [1:0] {
        MODE_SINGLE, MODE_SINGLE_CONT, MODE_SCAN, MODE_SCAN_CONT
    } conv_mode_t;

    typedef enum {
        ST_STARTUP, ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CAL, ST_TAIL,
        ST_HOLD
    } seq_state_t;

    // register bus request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // analog front end commands
    typedef struct packed {
        logic power_on;
        logic sample;
        logic [3:0] chan;
        logic [9:0] dac;
    } afe_ctrl_t;
endpackage

// ### src/adc_clock_div.sv
`timescale 1ns/1ns
`default_nettype none
module adc_clock_div
    import sar_adc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // settings
    input wire logic improved,
    input wire logic [1:0] basic_clock_select,
    input wire logic [7:0] div_value,
    input wire logic run,
    // basic clock tick
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t st, next_st;
    logic [7:0] limit;

    // compat codes 00:/4 01:/2 10:/16 11:/8, improved takes div_value+1
    always_comb begin
        case (basic_clock_select)
            2'h0: limit = 8'h03;
            2'h1: limit = 8'h01;
            2'h2: limit = 8'h0F;
            default: limit = 8'h07;
        endcase
        if (improved) begin
            limit = div_value;
        end
    end

    // counter held in reset while the converter sleeps, saves power
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.cnt = 8'h00;
        end else if (st.cnt >= limit) begin
            next_st.cnt = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

// ### src/sar_adc_sequencer.sv
// Operation
// - convert one of 14 channels to 10 bits via sample and hold
// - successive approximation, one bit per step, MSB first
// - software sets sample and conversion time, two timing schemes
// - optional 8-bit mode finishing in fewer cycles
// - overrun flag raised when unread result is overwritten
// - wait-for-read option holds next conversion until result read
// - single mode converts chosen channel once then stops
// - single continuous mode repeats chosen channel endlessly
// - scan mode converts configured channels downward once each
// - scan continuous restarts the sequence after every pass
// - injected channel inserted, interrupted sequence resumes intact
// - each result raises a transfer request for the event controller
// - calibration runs after reset and during operation
// - calibration sits inside conversion cycle, invisible to software
// - one digital-disable bit per analog pin
// - unused channels readable as digital inputs
// - converter powered down when no conversion runs
// - compat basic clock 00 /4, 01 /2, 10 /16, 11 /8
// - compat sample time 8, 16, 32, 64 basic clocks
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int NUM_CHAN = 14,
    parameter int RES_BITS = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire reg_req_t reg_req,
    output logic [15:0] rdata,
    // analog front end
    output afe_ctrl_t afe,
    input wire logic comp_in,
    // channel pins, digital side
    input wire logic [NUM_CHAN-1:0] pin_in,
    output logic [NUM_CHAN-1:0] analog_pin_digital_disable,
    // events
    output logic busy,
    output logic conv_done,
    output logic transfer_req
);
    initial begin
        if (NUM_CHAN < 1 || NUM_CHAN > 16 || RES_BITS != 10) begin
            $error("sar_adc_sequencer: unsupported parameters");
        end
    end

    typedef struct packed {
        seq_state_t fsm;
        logic [15:0] ctrl;
        logic [15:0] timing;
        logic [13:0] digdis;
        logic [9:0] result;
        logic [3:0] res_chan;
        logic res_inj;
        logic res_valid;
        logic overrun;
        logic [3:0] cur_chan;
        logic [3:0] seq_chan;
        logic cur_inj;
        logic inj_pend;
        logic [3:0] inj_chan;
        logic [9:0] sar;
        logic [3:0] bit_idx;
        logic [7:0] bc_cnt;
        logic [9:0] cal_trim;
        logic [2:0] tail_cnt;
        logic busy;
        logic done;
        logic xfer;
        logic [15:0] rdata;
        logic [41:0] pin_sync;
        logic [13:0] pin_val;
        afe_ctrl_t afe_out;
    } seq_state_all_t;

    seq_state_all_t st, next_st;
    logic tick;
    logic running;
    conv_mode_t mode;
    logic eight;
    logic [7:0] sample_len;
    logic [3:0] last_bit;

    // sample time: compat code, or improved count from timing register
    function automatic logic [7:0] sample_bc(input logic imp,
            input logic [1:0] code, input logic [7:0] cnt);
        if (imp) begin
            return cnt;
        end
        case (code)
            2'h0: return 8'h08;
            2'h1: return 8'h10;
            2'h2: return 8'h20;
            default: return 8'h40;
        endcase
    endfunction

    assign mode = conv_mode_t'(st.ctrl[CTRL_MODE_HI:CTRL_MODE_LO]);
    assign eight = st.ctrl[CTRL_EIGHT_BIT];
    assign sample_len = sample_bc(st.ctrl[CTRL_IMPROVED],
        st.ctrl[CTRL_STC_HI:CTRL_STC_LO],
        st.timing[TIM_SAMPLE_HI:TIM_SAMPLE_LO]);
    assign last_bit = eight ? 4'h2 : 4'h0;
    assign running = st.fsm != ST_IDLE && st.fsm != ST_HOLD;

    adc_clock_div u_div (
        .core_clk(core_clk),
        .srst(srst),
        .improved(st.ctrl[CTRL_IMPROVED]),
        .basic_clock_select(st.ctrl[CTRL_CTC_HI:CTRL_CTC_LO]),
        .div_value(st.timing[TIM_DIV_HI:TIM_DIV_LO]),
        .run(running),
        .tick(tick)
    );

    always_comb begin
        logic rd_result;
        logic finish;
        rd_result = reg_req.rd && reg_req.addr == ADDR_RESULT;
        finish = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        next_st.xfer = 1'b0;
        // pins pass three flops; a change counts when stages 2 and 3 agree
        next_st.pin_sync = {st.pin_sync[27:0], 14'(pin_in)};
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (st.pin_sync[14+i] == st.pin_sync[28+i]) begin
                next_st.pin_val[i] = st.pin_sync[28+i];
            end
        end

        // register writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_CTRL: next_st.ctrl = reg_req.wdata;
                ADDR_TIMING: next_st.timing = reg_req.wdata;
                ADDR_DIGDIS: next_st.digdis = reg_req.wdata[13:0];
                ADDR_INJECT: begin
                    next_st.inj_pend = 1'b1;
                    next_st.inj_chan = reg_req.wdata[INJ_CHAN_HI:INJ_CHAN_LO];
                end
                ADDR_STATUS: begin
                    if (reg_req.wdata[1]) begin
                        next_st.overrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // reading the result frees it
        if (rd_result) begin
            next_st.res_valid = 1'b0;
        end

        // register reads, answered one cycle later
        case (reg_req.addr)
            ADDR_CTRL: next_st.rdata = st.ctrl;
            ADDR_STATUS: next_st.rdata = {8'h00, st.inj_pend, 3'h0,
                st.res_inj, st.res_valid, st.overrun, st.busy};
            ADDR_RESULT: next_st.rdata = {st.res_chan, 2'h0, st.result};
            ADDR_INJECT: next_st.rdata = {12'h000, st.inj_chan};
            ADDR_DIGDIS: next_st.rdata = {2'h0, st.digdis};
            ADDR_PORTIN: next_st.rdata = {2'h0, st.pin_val & ~st.digdis};
            ADDR_TIMING: next_st.rdata = st.timing;
            default: next_st.rdata = 16'h0000;
        endcase
        if (!reg_req.rd) begin
            next_st.rdata = 16'h0000;
        end

        case (st.fsm)
            // power-on calibration before first conversion
            ST_STARTUP: begin
                if (tick) begin
                    next_st.bc_cnt = st.bc_cnt + 8'h01;
                    next_st.cal_trim = st.cal_trim + 10'h001;
                    if (st.bc_cnt == 8'(STARTUP_CAL_BC - 1)) begin
                        next_st.fsm = ST_IDLE;
                        next_st.bc_cnt = 8'h00;
                    end
                end
            end
            ST_IDLE: begin
                if (st.inj_pend) begin
                    next_st.cur_chan = st.inj_chan;
                    next_st.cur_inj = 1'b1;
                    next_st.inj_pend = reg_req.wr
                        && reg_req.addr == ADDR_INJECT; // new write wins
                    next_st.fsm = ST_SAMPLE;
                end else if (st.ctrl[CTRL_START]) begin
                    next_st.cur_chan = st.ctrl[CTRL_CHAN_HI:CTRL_CHAN_LO];
                    next_st.seq_chan = st.ctrl[CTRL_CHAN_HI:CTRL_CHAN_LO];
                    next_st.cur_inj = 1'b0;
                    next_st.fsm = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                next_st.busy = 1'b1;
                if (tick) begin
                    next_st.bc_cnt = st.bc_cnt + 8'h01;
                    if (st.bc_cnt == sample_len - 8'h01) begin
                        next_st.bc_cnt = 8'h00;
                        next_st.fsm = ST_CONVERT;
                        next_st.bit_idx = 4'h9;
                        next_st.sar = 10'h200;
                    end
                end
            end
            // each step sets the trial bit, comparator decides keep
            ST_CONVERT: begin
                if (tick) begin
                    next_st.bc_cnt = st.bc_cnt + 8'h01;
                    if (st.bc_cnt == 8'(STEP_BC - 1)) begin
                        next_st.bc_cnt = 8'h00;
                        if (!comp_in) begin
                            next_st.sar[st.bit_idx] = 1'b0;
                        end
                        if (st.bit_idx == last_bit) begin
                            next_st.fsm = ST_CAL;
                        end else begin
                            next_st.bit_idx = st.bit_idx - 4'h1;
                            next_st.sar[st.bit_idx - 4'h1] = 1'b1;
                        end
                    end
                end
            end
            // fixed calibration slot, same length every time
            ST_CAL: begin
                if (tick) begin
                    next_st.bc_cnt = st.bc_cnt + 8'h01;
                    if (st.bc_cnt == 8'(CAL_BC - 1)) begin
                        next_st.bc_cnt = 8'h00;
                        next_st.cal_trim = st.cal_trim + 10'h001;
                        next_st.fsm = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                next_st.tail_cnt = st.tail_cnt + 3'h1;
                if (st.tail_cnt == 3'(TAIL_SYS - 1)) begin
                    next_st.tail_cnt = 3'h0;
                    if (st.ctrl[CTRL_WAIT_READ] && st.res_valid
                            && !rd_result) begin
                        next_st.fsm = ST_HOLD;
                    end else begin
                        finish = 1'b1;
                    end
                end
            end
            // unread result blocks the write until software reads it
            ST_HOLD: begin
                if (!st.res_valid || rd_result) begin
                    finish = 1'b1;
                end
            end
            default: next_st.fsm = ST_IDLE;
        endcase

        if (finish) begin
            next_st.result = eight ? {2'h0, st.sar[9:2]} : st.sar;
            next_st.res_chan = st.cur_chan;
            next_st.res_inj = st.cur_inj;
            next_st.res_valid = 1'b1;
            next_st.done = 1'b1;
            next_st.xfer = 1'b1;
            next_st.fsm = ST_IDLE;
            next_st.busy = 1'b0; // low in the result cycle, rises in sample
            if (st.cur_inj) begin // resume the interrupted sequence
                if (st.ctrl[CTRL_START]) begin
                    next_st.cur_chan = st.seq_chan;
                    next_st.cur_inj = 1'b0;
                    next_st.fsm = ST_SAMPLE;
                end
            end else begin
                case (mode)
                    MODE_SINGLE: next_st.ctrl[CTRL_START] = 1'b0;
                    MODE_SINGLE_CONT: next_st.fsm = ST_SAMPLE;
                    MODE_SCAN, MODE_SCAN_CONT: begin
                        if (st.seq_chan != 4'h0) begin
                            next_st.seq_chan = st.seq_chan - 4'h1;
                            next_st.fsm = ST_SAMPLE;
                        end else if (mode == MODE_SCAN_CONT) begin
                            next_st.seq_chan =
                                st.ctrl[CTRL_CHAN_HI:CTRL_CHAN_LO];
                            next_st.fsm = ST_SAMPLE;
                        end else begin
                            next_st.ctrl[CTRL_START] = 1'b0;
                        end
                    end
                    default: next_st.ctrl[CTRL_START] = 1'b0;
                endcase
                if (st.inj_pend) begin
                    next_st.fsm = ST_IDLE; // injection taken next cycle
                end
                if (next_st.fsm == ST_SAMPLE && mode != MODE_SINGLE_CONT) begin
                    next_st.cur_chan = next_st.seq_chan;
                end
            end
        end
        // set wins over the clear
        if (finish && st.res_valid && !rd_result) begin
            next_st.overrun = 1'b1;
        end
        // front end lines registered; dac shows the trim in the cal slot
        next_st.afe_out.power_on = running;
        next_st.afe_out.sample = st.fsm == ST_SAMPLE;
        next_st.afe_out.chan = st.cur_chan;
        next_st.afe_out.dac = st.fsm == ST_CAL ? st.cal_trim : st.sar;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
            st.fsm <= ST_STARTUP;
            st.ctrl <= CTRL_RESET;
            st.timing <= TIMING_RESET;
            st.digdis <= DIGDIS_RESET;
            st.afe_out.power_on <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops; power only while running
    assign rdata = st.rdata;
    assign afe = st.afe_out;
    assign analog_pin_digital_disable = NUM_CHAN'(st.digdis);
    assign busy = st.busy;
    assign conv_done = st.done;
    assign transfer_req = st.xfer;
endmodule
`default_nettype wire

// ### testbench/sar_adc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sar_adc_monitor
    import sar_adc_pkg::*;
#(
    parameter int NUM_CHAN = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire reg_req_t reg_req,
    input wire logic [15:0] rdata,
    // converter side
    input wire afe_ctrl_t afe,
    input wire logic comp_in,
    input wire logic [NUM_CHAN-1:0] pin_in,
    input wire logic [NUM_CHAN-1:0] analog_pin_digital_disable,
    // events
    input wire logic busy,
    input wire logic conv_done,
    input wire logic transfer_req
);
    logic [11:0] busy_cnt;

    // length of the current busy stretch, saturating
    always_ff @(posedge core_clk) begin
        if (srst || !busy) begin
            busy_cnt <= 12'h000;
        end else if (busy_cnt != 12'hFFF) begin
            busy_cnt <= busy_cnt + 12'h001;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_start;
        $rose(busy);
    endsequence
    sequence s_finish;
        $fell(busy) ##0 conv_done;
    endsequence

    a_xfer_with_done: assert property (transfer_req == conv_done)
        else $error("transfer request not aligned with completion");
    a_done_ends_busy: assert property (conv_done |-> s_finish)
        else $error("completion without busy falling");
    a_done_one_cycle: assert property (conv_done |=> !conv_done)
        else $error("completion pulse too long");
    a_start_samples: assert property (s_start |-> afe.sample)
        else $error("conversion started without sampling");
    a_busy_powered: assert property (busy && !$stable(afe.dac)
        |-> afe.power_on)
        else $error("converter unpowered while stepping");
    a_conv_minimum: assert property (conv_done |-> busy_cnt >= 12'h064)
        else $error("conversion shorter than any legal setting");
    a_chan_steady: assert property ($past(busy) && busy
        |-> $stable(afe.chan))
        else $error("channel changed mid conversion");
    a_digdis_write: assert property (
        !$past(reg_req.wr) |-> $stable(analog_pin_digital_disable))
        else $error("digital disable changed without a write");
    a_reset_state: assert property (disable iff (1'b0)
        srst |=> afe.power_on && !busy && !conv_done)
        else $error("reset state wrong");
endmodule
`default_nettype wire

// ### testbench/analog_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module analog_source_model
    import sar_adc_pkg::*;
(
    // clock
    input wire logic core_clk,
    // channel levels, ten bits each
    input wire logic [139:0] levels,
    // converter side
    input wire afe_ctrl_t afe,
    output logic comp_in,
    output logic [13:0] pin_in
);
    logic wobble = 1'b0;
    logic [9:0] lvl;

    // unpowered comparator output is garbage, so keep it moving
    always @(posedge core_clk) wobble <= !wobble;

    // comparator against trial code; pins read the level's top bit
    always_comb begin
        lvl = (afe.chan < 4'hE) ? levels[afe.chan*10 +: 10] : 10'h000;
        comp_in = afe.power_on ? (lvl >= afe.dac) : wobble;
        for (int i = 0; i < 14; i++) begin
            pin_in[i] = levels[i*10+9];
        end
    end
endmodule
`default_nettype wire

// ### testbench/sar_adc_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb_top;
    import sar_adc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    reg_req_t req = '0;
    logic [15:0] rdata;
    afe_ctrl_t afe;
    logic comp_in, busy, conv_done, transfer_req;
    logic [13:0] pin_in, dis;
    logic [139:0] levels;
    logic [15:0] d;
    int fail_count = 0;
    int n_compared = 0;
    int cyc, dv, sm, lo;
    int divs[4] = '{4, 2, 16, 8};
    int tc[9] = '{0, 1, 2, 3, 1, 1, 1, 0, 0};
    int ts[9] = '{0, 0, 0, 0, 1, 2, 3, 0, 0};
    int te[9] = '{0, 0, 0, 0, 0, 0, 0, 1, 0};
    int seq[4] = '{2, 5, 1, 0};

    always #2 core_clk = !core_clk;

    sar_adc_sequencer #(.NUM_CHAN(14), .RES_BITS(10)) uut (
        .core_clk(core_clk), .srst(srst), .reg_req(req), .rdata(rdata),
        .afe(afe), .comp_in(comp_in), .pin_in(pin_in),
        .analog_pin_digital_disable(dis), .busy(busy),
        .conv_done(conv_done), .transfer_req(transfer_req));
    analog_source_model src (
        .core_clk(core_clk), .levels(levels), .afe(afe),
        .comp_in(comp_in), .pin_in(pin_in));

    function automatic logic [9:0] lv(input int c);
        return 10'(c * 73 + 5);
    endfunction

    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_time(input string nm, input int a, input int b,
                            input int g);
        n_compared++;
        if (g < a || g > b) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, a, b, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // result word: channel on top, value right-aligned
    task automatic rdres(input int c, input int e);
        logic [9:0] v;
        v = lv(c);
        rd(ADDR_RESULT, d);
        chk("result", e ? {4'(c), 4'h0, v[9:2]} : {4'(c), 2'b00, v}, d);
    endtask

    // bounded wait; n is -1 when nothing came
    task automatic wait_done(input int lim, input bit must, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (conv_done !== 1'b1 && n < lim);
        if (conv_done !== 1'b1) n = -1;
        if (n < 0 && must) begin
            fail_count++;
            $display("CHECK FAILED conv_done expected 1 seen 0");
            conclude();
        end
    endtask

    initial begin
        for (int c = 0; c < 14; c++) levels[c*10 +: 10] = lv(c);
        repeat (10) @(posedge core_clk);
        chk("power_on", 16'h0001, {15'h0000, afe.power_on});
        srst <= 1'b0;
        wr(ADDR_CTRL, 16'h0301);
        wait_done(2000, 1, cyc);
        chk_time("startup", 490, 530, cyc + 2);
        rdres(3, 0);
        rd(ADDR_CTRL, d);
        chk("ctrl", 16'h0300, d);
        repeat (8) @(posedge core_clk);
        chk("power_on", 16'h0000, {15'h0000, afe.power_on});
        rd(ADDR_TIMING, d);
        chk("timing", 16'h0310, d);
        rd(8'h1C, d);
        chk("unmapped", 16'h0000, d);
        // timing schemes, sample and clock selectors, 8-bit mode
        wr(ADDR_TIMING, 16'h0210);
        for (int i = 0; i < 9; i++) begin
            dv = (i == 8) ? 3 : divs[tc[i]];
            sm = (i == 8) ? 16 : 8 << ts[i];
            lo = (sm + 12 + 4 * (te[i] ? 8 : 10)) * dv + 6;
            wr(ADDR_CTRL, {2'(tc[i]), 2'(ts[i]), 4'h4, 2'b00,
                1'(i == 8), 1'(te[i]), 4'h1});
            wait_done(3000, 1, cyc);
            chk_time("conv_time", lo - dv - 2, lo + 2*dv + 3, cyc);
            rdres(4, te[i]);
        end
        // unread result overwritten
        wr(ADDR_CTRL, 16'h0001);
        wait_done(3000, 1, cyc);
        wr(ADDR_CTRL, 16'h0001);
        wait_done(3000, 1, cyc);
        rd(ADDR_STATUS, d);
        chk("status", 16'h0006, d & 16'h0006);
        wr(ADDR_STATUS, 16'h0002);
        rd(ADDR_STATUS, d);
        chk("status", 16'h0000, d & 16'h0002);
        rdres(0, 0);
        // continuous with wait-for-read
        wr(ADDR_CTRL, 16'h060B);
        wait_done(3000, 1, cyc);
        wait_done(700, 0, cyc);
        chk_time("held", -1, -1, cyc);
        rdres(6, 0);
        chk("released", 16'h0001, {15'h0000, conv_done});
        rdres(6, 0);
        wait_done(700, 1, cyc);
        wr(ADDR_CTRL, 16'h0000);
        wait_done(700, 0, cyc);
        repeat (4) @(posedge core_clk);
        chk("busy", 16'h0000, {15'h0000, busy});
        // scan with an injected channel
        wr(ADDR_CTRL, 16'h0205);
        wr(ADDR_INJECT, 16'h0005);
        for (int i = 0; i < 4; i++) begin
            wait_done(3000, 1, cyc);
            rdres(seq[i], 0);
        end
        wait_done(700, 0, cyc);
        chk_time("scan_end", -1, -1, cyc);
        // scan continuous wraps around
        wr(ADDR_CTRL, 16'h0107);
        for (int i = 0; i < 4; i++) begin
            wait_done(3000, 1, cyc);
            rdres(1 - i % 2, 0);
        end
        wr(ADDR_CTRL, 16'h0000);
        wait_done(700, 0, cyc);
        repeat (4) @(posedge core_clk);
        chk("busy", 16'h0000, {15'h0000, busy});
        // digital side of the channel pins
        wr(ADDR_DIGDIS, 16'h00F0);
        rd(ADDR_DIGDIS, d);
        chk("digdis", 16'h00F0, d);
        chk("digdis_pin", 16'h00F0, {2'b00, dis});
        repeat (4) @(posedge core_clk);
        rd(ADDR_PORTIN, d);
        chk("portin", {2'b00, pin_in & ~14'h00F0}, d);
        conclude();
    end
endmodule

bind sar_adc_sequencer sar_adc_monitor #(.NUM_CHAN(NUM_CHAN)) mon (
    .core_clk(core_clk), .srst(srst), .reg_req(reg_req), .rdata(rdata),
    .afe(afe), .comp_in(comp_in), .pin_in(pin_in),
    .analog_pin_digital_disable(analog_pin_digital_disable),
    .busy(busy), .conv_done(conv_done), .transfer_req(transfer_req));
`default_nettype wire
